/* include/pds_cfg.svh */
`ifndef PDS_CFG_SVH
`define PDS_CFG_SVH

// Register byte offsets
`define PDS_ADDR_CTRL      8'h00
`define PDS_ADDR_STATE     8'h04
`define PDS_ADDR_INT_STAT  8'h08
`define PDS_ADDR_INT_MASK  8'h0c

// Control register fields and reset value
`define PDS_CTRL_W         2
`define PDS_CTRL_START     0
`define PDS_CTRL_REMOTE    1
`define PDS_CTRL_RST       2'h0

// Event bits, shared by status and mask
`define PDS_EV_W           4
`define PDS_EV_NORMAL      0
`define PDS_EV_ERROR       1
`define PDS_EV_CLEAR       2
`define PDS_EV_STOP        3
`define PDS_EV_RST         4'h0

// LED chain and level inputs
`define PDS_CHAIN_W        8
`define PDS_LVL_W          4
`define PDS_LVL_ZERO       4'h0

// Flash timing
`define PDS_CLK_KHZ        250000
`define PDS_FLASH_HALF_MS  500
`define PDS_FLASH_CNT_W    27

`endif

/* include/pds_pkg.sv */
package pds_pkg;

  // Operating mode, Gray along idle -> run -> normal
  typedef enum logic [1:0] {
    PDS_IDLE  = 2'h0,
    PDS_RUN   = 2'h1,
    PDS_NORM  = 2'h3,
    PDS_FAULT = 2'h2
  } pds_mode_e;

  // Synchronised pin inputs
  typedef struct packed {
    logic overload;
    logic error;
    logic at_speed;
    logic rotating;
    logic start;
  } pds_in_s;

  // Outputs to motor, relays and panel
  typedef struct packed {
    logic       drive;
    logic       relay_normal;
    logic       relay_error;
    logic       led_status;
    logic       led_error;
    logic [7:0] chain;
  } pds_lamp_s;

  // Layout of the read-only state register
  typedef struct packed {
    logic      fault_latched;
    logic [3:0] fault_code;
    logic      spare;
    pds_mode_e mode;
    pds_in_s   pins;
  } pds_state_s;

endpackage : pds_pkg

/* hdl/pds_flash.sv */
`timescale 1ns/100ps
`default_nettype none
`include "pds_cfg.svh"

module pds_flash #(
  parameter int unsigned HALF_CYC = `PDS_FLASH_HALF_MS * `PDS_CLK_KHZ
) (
  // Clock and control
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // Common flash phase
  output var  logic phase
);

  logic [`PDS_FLASH_CNT_W-1:0] cnt_r;
  logic [`PDS_FLASH_CNT_W-1:0] cnt_nxt;
  logic                        phase_r;
  logic                        phase_nxt;

  // Free-running, never restarted, so every flashing LED shares one phase
  always_comb begin
    cnt_nxt   = cnt_r + 1'b1;
    phase_nxt = phase_r;
    if (cnt_r == `PDS_FLASH_CNT_W'(HALF_CYC - 1)) begin
      cnt_nxt   = '0;
      phase_nxt = ~phase_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r   <= '0;
      phase_r <= 1'b0;
    end else if (ce) begin
      cnt_r   <= cnt_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign phase = phase_r;

endmodule : pds_flash
`default_nettype wire

/* hdl/pds_top.sv */
// Overview of operation
// - Normal operation at 80 percent setpoint speed
// - Stop command always switches motor drive off
// - Error forces drive off, error relay active
// - Normal relay, steady green only in normal
// - Red LED steady while error present or malfunction latched
// - Green flashes while rotating or starting up
// - Run-down speed shown, dark below indication range
// - Malfunction: drive off, red on, code flashes
// - Stop command clears latched malfunction indication once error pin is gone
// - Run-up flashes green, chain shows speed step
// - Normal operation chain shows power bar
// - Overload in normal flashes red, no failure
`timescale 1ns/100ps
`default_nettype none
`include "pds_cfg.svh"

module pds_top #(
  parameter int unsigned FLASH_HALF_CYC = `PDS_FLASH_HALF_MS * `PDS_CLK_KHZ
) (
  // Clock, reset, enable
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  // APB slave
  input  wire logic [7:0]             paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output var  logic [31:0]            prdata,
  output var  logic                   pready,
  output var  logic                   pslverr,
  // Panel and pump pins, asynchronous
  input  wire logic                   start_pin,
  input  wire logic                   rotating_pin,
  input  wire logic                   at_speed_pin,
  input  wire logic                   error_pin,
  input  wire logic                   overload_pin,
  input  wire logic [3:0]             fault_code_pin,
  // Levels from the drive controller, same clock
  input  wire logic [`PDS_LVL_W-1:0]   speed_lvl,
  input  wire logic [`PDS_LVL_W-1:0]   power_lvl,
  // Motor, relays and LEDs
  output var  logic                   motor_drive,
  output var  logic                   relay_normal,
  output var  logic                   relay_error,
  output var  logic                   led_status,
  output var  logic                   led_error,
  output var  logic [`PDS_CHAIN_W-1:0] led_chain,
  // Interrupt
  output var  logic                   irq
);

  // One LED lit at position n, none for zero or out of range
  function automatic logic [`PDS_CHAIN_W-1:0] pds_one_hot(input logic [`PDS_LVL_W-1:0] n);
    logic [`PDS_CHAIN_W-1:0] v;
    v = '0;
    for (int i = 0; i < `PDS_CHAIN_W; i++) begin
      if (n == `PDS_LVL_W'(i + 1)) begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction : pds_one_hot

  // Bar filling from the bottom, n LEDs lit
  function automatic logic [`PDS_CHAIN_W-1:0] pds_bar(input logic [`PDS_LVL_W-1:0] n);
    logic [`PDS_CHAIN_W-1:0] v;
    v = '0;
    for (int i = 0; i < `PDS_CHAIN_W; i++) begin
      if (n > `PDS_LVL_W'(i)) begin
        v[i] = 1'b1;
      end
    end
    return v;
  endfunction : pds_bar

  // Address decode, shared by read and write paths
  function automatic logic pds_hit(input logic [7:0] a);
    return (a == `PDS_ADDR_CTRL) || (a == `PDS_ADDR_STATE) ||
           (a == `PDS_ADDR_INT_STAT) || (a == `PDS_ADDR_INT_MASK);
  endfunction : pds_hit

  // Synchronisers
  pds_pkg::pds_in_s          sync1_r;
  pds_pkg::pds_in_s          sync2_r;
  logic [3:0]                code1_r;
  logic [3:0]                code2_r;

  // Control state
  logic [`PDS_CTRL_W-1:0]     ctrl_r;
  logic [`PDS_CTRL_W-1:0]     ctrl_nxt;
  logic                      start_prev_r;
  logic                      start_prev_nxt;
  logic                      err_prev_r;
  logic                      err_prev_nxt;
  logic                      fault_lat_r;
  logic                      fault_lat_nxt;
  logic [3:0]                fault_code_r;
  logic [3:0]                fault_code_nxt;
  pds_pkg::pds_mode_e        mode_r;
  pds_pkg::pds_mode_e        mode_nxt;
  pds_pkg::pds_lamp_s        lamp_r;
  pds_pkg::pds_lamp_s        lamp_nxt;

  // Interrupt state
  logic [`PDS_EV_W-1:0]       int_stat_r;
  logic [`PDS_EV_W-1:0]       int_stat_nxt;
  logic [`PDS_EV_W-1:0]       int_mask_r;
  logic [`PDS_EV_W-1:0]       int_mask_nxt;
  logic                      irq_r;
  logic                      irq_nxt;

  // Bus state
  logic [31:0]               prdata_r;
  logic [31:0]               prdata_nxt;
  logic                      pready_r;
  logic                      pready_nxt;
  logic                      pslverr_r;
  logic                      pslverr_nxt;

  // Combinational helpers
  pds_pkg::pds_in_s          pins;
  pds_pkg::pds_state_s       state_rd;
  logic                      flash;
  logic                      setup_ph;
  logic                      wr_en;
  logic                      start_cmd;
  logic                      stop_ev;
  logic                      err_rise;
  logic                      fault_clr;
  logic                      err_now;
  logic                      normal;
  logic [`PDS_EV_W-1:0]       ev;

  pds_flash #(
    .HALF_CYC (FLASH_HALF_CYC)
  ) u_flash (
    .mclk  (mclk),
    .rst   (rst),
    .ce    (ce),
    .phase (flash)
  );

  always_comb begin
    pins     = sync2_r;
    setup_ph = psel && !penable && !pready_r;
    wr_en    = psel && penable && pready_r && pwrite && pds_hit(paddr);

    // Bus registers
    ctrl_nxt     = ctrl_r;
    int_mask_nxt = int_mask_r;
    if (wr_en && (paddr == `PDS_ADDR_CTRL)) begin
      ctrl_nxt = pwdata[`PDS_CTRL_W-1:0];
    end
    if (wr_en && (paddr == `PDS_ADDR_INT_MASK)) begin
      int_mask_nxt = pwdata[`PDS_EV_W-1:0];
    end

    // Local key unless remote control owns the command
    start_cmd = ctrl_r[`PDS_CTRL_REMOTE] ? ctrl_r[`PDS_CTRL_START] : pins.start;
    start_prev_nxt = start_cmd;
    // A remote write of stop counts even when already stopped
    stop_ev = (start_prev_r && !start_cmd) ||
              (wr_en && (paddr == `PDS_ADDR_CTRL) &&
               pwdata[`PDS_CTRL_REMOTE] && !pwdata[`PDS_CTRL_START]);

    // Latched malfunction; a new error wins over a clearing stop
    err_prev_nxt   = pins.error;
    err_rise       = pins.error && !err_prev_r;
    fault_clr      = stop_ev && !pins.error && fault_lat_r;
    fault_lat_nxt  = fault_lat_r;
    fault_code_nxt = fault_code_r;
    if (err_rise) begin
      fault_lat_nxt  = 1'b1;
      fault_code_nxt = code2_r;
    end else if (fault_clr) begin
      fault_lat_nxt = 1'b0;
    end

    err_now = pins.error || fault_lat_r;
    // Threshold flag arrives already compared at the default 80 percent
    normal  = start_cmd && pins.rotating && pins.at_speed && !err_now;

    if (err_now) begin
      mode_nxt = pds_pkg::PDS_FAULT;
    end else if (normal) begin
      mode_nxt = pds_pkg::PDS_NORM;
    end else if (start_cmd || pins.rotating) begin
      mode_nxt = pds_pkg::PDS_RUN;
    end else begin
      mode_nxt = pds_pkg::PDS_IDLE;
    end

    lamp_nxt              = '0;
    lamp_nxt.drive        = start_cmd && !err_now;
    lamp_nxt.relay_normal = normal;
    lamp_nxt.relay_error  = err_now;
    lamp_nxt.led_error    = err_now;
    unique case (mode_nxt)
      pds_pkg::PDS_IDLE: begin
        lamp_nxt.led_status = 1'b0;
        lamp_nxt.chain      = '0;
      end
      pds_pkg::PDS_RUN: begin
        // Below the indication range on run-down both go dark early
        if (pins.rotating && !start_cmd && (speed_lvl == `PDS_LVL_ZERO)) begin
          lamp_nxt.led_status = 1'b0;
        end else begin
          lamp_nxt.led_status = flash;
        end
        lamp_nxt.chain = pins.rotating ? pds_one_hot(speed_lvl) : '0;
      end
      pds_pkg::PDS_NORM: begin
        lamp_nxt.led_status = 1'b1;
        lamp_nxt.chain      = pds_bar(power_lvl);
        lamp_nxt.led_error  = pins.overload && flash;
      end
      pds_pkg::PDS_FAULT: begin
        lamp_nxt.led_status = pins.rotating && flash;
        // Failure code outranks any speed display
        lamp_nxt.chain = fault_lat_r ? (pds_one_hot(fault_code_r) & {`PDS_CHAIN_W{flash}}) : '0;
      end
    endcase

    // Events are sticky; a fresh event wins over a write-one clear
    ev = '0;
    ev[`PDS_EV_NORMAL] = (mode_nxt == pds_pkg::PDS_NORM) && (mode_r != pds_pkg::PDS_NORM);
    ev[`PDS_EV_ERROR]  = err_rise;
    ev[`PDS_EV_CLEAR]  = fault_clr;
    ev[`PDS_EV_STOP]   = stop_ev;
    int_stat_nxt = int_stat_r;
    if (wr_en && (paddr == `PDS_ADDR_INT_STAT)) begin
      int_stat_nxt = int_stat_r & ~pwdata[`PDS_EV_W-1:0];
    end
    int_stat_nxt = int_stat_nxt | ev;
    irq_nxt      = |(int_stat_r & int_mask_r);

    // Read data is sampled in the setup cycle, answer one cycle later
    state_rd               = '0;
    state_rd.fault_latched = fault_lat_r;
    state_rd.fault_code    = fault_code_r;
    state_rd.mode          = mode_r;
    state_rd.pins          = pins;
    pready_nxt  = setup_ph;
    pslverr_nxt = setup_ph && !pds_hit(paddr);
    prdata_nxt  = '0;
    if (setup_ph && !pwrite) begin
      unique case (paddr)
        `PDS_ADDR_CTRL:     prdata_nxt = 32'(ctrl_r);
        `PDS_ADDR_STATE:    prdata_nxt = 32'(state_rd);
        `PDS_ADDR_INT_STAT: prdata_nxt = 32'(int_stat_r);
        `PDS_ADDR_INT_MASK: prdata_nxt = 32'(int_mask_r);
        default:            prdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_r      <= '0;
      sync2_r      <= '0;
      code1_r      <= '0;
      code2_r      <= '0;
      ctrl_r       <= `PDS_CTRL_RST;
      start_prev_r <= 1'b0;
      err_prev_r   <= 1'b0;
      fault_lat_r  <= 1'b0;
      fault_code_r <= '0;
      mode_r       <= pds_pkg::PDS_IDLE;
      lamp_r       <= '0;
      int_stat_r   <= `PDS_EV_RST;
      int_mask_r   <= `PDS_EV_RST;
      irq_r        <= 1'b0;
      prdata_r     <= '0;
      pready_r     <= 1'b0;
      pslverr_r    <= 1'b0;
    end else if (ce) begin
      sync1_r      <= '{overload: overload_pin, error: error_pin, at_speed: at_speed_pin,
                        rotating: rotating_pin, start: start_pin};
      sync2_r      <= sync1_r;
      code1_r      <= fault_code_pin;
      code2_r      <= code1_r;
      ctrl_r       <= ctrl_nxt;
      start_prev_r <= start_prev_nxt;
      err_prev_r   <= err_prev_nxt;
      fault_lat_r  <= fault_lat_nxt;
      fault_code_r <= fault_code_nxt;
      mode_r       <= mode_nxt;
      lamp_r       <= lamp_nxt;
      int_stat_r   <= int_stat_nxt;
      int_mask_r   <= int_mask_nxt;
      irq_r        <= irq_nxt;
      prdata_r     <= prdata_nxt;
      pready_r     <= pready_nxt;
      pslverr_r    <= pslverr_nxt;
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign motor_drive  = lamp_r.drive;
  assign relay_normal = lamp_r.relay_normal;
  assign relay_error  = lamp_r.relay_error;
  assign led_status   = lamp_r.led_status;
  assign led_error    = lamp_r.led_error;
  assign led_chain    = lamp_r.chain;
  assign irq          = irq_r;

endmodule : pds_top
`default_nettype wire

/* dv/pds_top_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module pds_top_monitor #(
  parameter int unsigned FLASH_HALF_CYC = 8
) (
  // Clock and bus
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  // Pump and panel
  input wire logic       rotating_pin,
  input wire logic       error_pin,
  input wire logic       overload_pin,
  input wire logic [3:0] power_lvl,
  input wire logic       motor_drive,
  input wire logic       relay_normal,
  input wire logic       relay_error,
  input wire logic       led_status,
  input wire logic       led_error,
  input wire logic [7:0] led_chain
);
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Pins need two sync stages plus the output flop
  chk_err_drive: assert property ((error_pin && ce) [*4] |-> relay_error && !motor_drive && !relay_normal)
    else $error("drive not off under error");
  chk_red_track: assert property (!relay_normal |-> led_error == relay_error)
    else $error("red lamp differs from error relay");
  chk_normal_set: assert property (relay_normal |-> led_status && motor_drive && !relay_error)
    else $error("normal relay without steady green");
  chk_power_bar: assert property (relay_normal && $past(ce)
    |-> led_chain == 8'((9'h1 << $past(power_lvl)) - 9'h1)) else $error("power bar wrong");
  chk_overload_red: assert property (relay_normal && led_error |-> $past(overload_pin, 3))
    else $error("red lamp in normal without overload");
  chk_code_onehot: assert property (relay_error |-> $onehot0(led_chain))
    else $error("several chain lamps in fault");
  chk_still_dark: assert property ((ce && !rotating_pin) [*5] ##0 !motor_drive |-> !led_status)
    else $error("green lit at standstill");
  chk_bus_ready: assert property (psel && !penable && ce |=> pready)
    else $error("no ready after setup");
endmodule : pds_top_monitor

bind pds_top pds_top_monitor #(.FLASH_HALF_CYC(FLASH_HALF_CYC)) u_mon (.mclk, .rst, .ce, .psel, .penable, .pready,
  .rotating_pin, .error_pin, .overload_pin, .power_lvl, .motor_drive, .relay_normal, .relay_error, .led_status,
  .led_error, .led_chain);
`default_nettype wire

/* dv/pds_pump_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pds_pump_model #(
  parameter int SET = 800,
  parameter int ACC = 4
) (
  // Clock and drive command
  input  wire logic       mclk,
  input  wire logic       motor_drive,
  // Speed feedback
  output var  logic       rotating_pin,
  output var  logic       at_speed_pin,
  output var  logic [3:0] speed_lvl
);
  // Rotor Hz; slow ramp keeps every state visible for many cycles
  int f = 0;
  always @(posedge mclk) begin
    if (motor_drive === 1'h1)
      f <= (f + ACC > SET) ? SET : f + ACC;
    else
      f <= (f < ACC) ? 0 : f - ACC;
  end
  always_comb begin
    rotating_pin = f > 0;
    at_speed_pin = f * 10 >= SET * 8;
    speed_lvl = (f < 250) ? 4'h0 : 4'(f * 8 / SET);
  end
endmodule : pds_pump_model
`default_nettype wire

/* dv/test_pump_drive_status_indicator.sv */
`timescale 1ns/100ps
`default_nettype none
module test_pump_drive_status_indicator;
  logic        mclk = 1'h0, rst = 1'h1, ce = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        start_pin = 1'h0, error_pin = 1'h0, overload_pin = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  fault_code_pin = 4'h0, power_lvl = 4'h0, speed_lvl, sl;
  logic        pready, pslverr, irq, rotating_pin, at_speed_pin;
  logic        motor_drive, relay_normal, relay_error, led_status, led_error;
  logic [7:0]  led_chain, chain_or;
  logic [32:0] q;
  int          miscompares = 0, checks = 0, v;

  pds_top #(.FLASH_HALF_CYC(8)) u_dut (.mclk, .rst, .ce, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .start_pin, .rotating_pin, .at_speed_pin, .error_pin, .overload_pin, .fault_code_pin,
    .speed_lvl, .power_lvl, .motor_drive, .relay_normal, .relay_error, .led_status, .led_error, .led_chain, .irq);
  pds_pump_model u_pump (.mclk, .motor_drive, .rotating_pin, .at_speed_pin, .speed_lvl);

  initial forever #2 mclk = ~mclk;

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic cmp(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp

  task automatic tick(inout int n);
    @(posedge mclk);
    n++;
    if (n > 2000) begin
      cmp("wait", 33'h0, 33'h1);
      give_verdict();
    end
  endtask : tick

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    tick(n);
    penable <= 1'h1;
    tick(n);
    while (pready !== 1'h1) tick(n);
    q = {pslverr, prdata};
    psel <= 1'h0;
    penable <= 1'h0;
    tick(n);
  endtask : apb

  task automatic wait_sig(input int k);
    int n;
    n = 0;
    while (k == 0 ? relay_normal !== 1'h1 : k == 1 ? speed_lvl !== 4'h0 : rotating_pin !== 1'h0) tick(n);
  endtask : wait_sig

  // Expected {drive, normal, error relay, green, red}; lamps 0 off, 1 on, 2 flash
  function automatic logic [6:0] want(input logic s, r, a, e);
    logic n;
    n = s & r & a & !e;
    return {s & !e, n, e, n ? 2'h1 : (r | (s & !e)) ? 2'h2 : 2'h0, e ? 2'h1 : 2'h0};
  endfunction : want

  function automatic logic [1:0] lv(input int n);
    return n == 0 ? 2'h0 : n == 32 ? 2'h1 : 2'h2;
  endfunction : lv

  // Two flash periods after the pin latency
  task automatic look(input logic [6:0] exp);
    int ns, ne;
    ns = 0;
    ne = 0;
    chain_or = 8'h0;
    for (int i = 0; i < 36; i++) begin
      @(posedge mclk);
      ns += (i >= 4 && led_status === 1'h1);
      ne += (i >= 4 && led_error === 1'h1);
      if (i >= 4) chain_or |= led_chain;
    end
    cmp("lamps", {motor_drive, relay_normal, relay_error, lv(ns), lv(ne)}, exp);
  endtask : look

  initial begin
    v = $urandom(9);
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    cmp("idle", {motor_drive, relay_normal, relay_error, led_status, led_error, led_chain, irq}, 33'h0);
    for (int a = 0; a <= 16; a += 4) begin
      apb(1'h0, 8'(a), 32'h0);
      cmp("reg", q, (a == 16) ? 33'h100000000 : 33'h0);
    end
    apb(1'h1, 8'h0c, 32'hffffffff);
    apb(1'h0, 8'h0c, 32'h0);
    cmp("mask", q, 33'hf);
    start_pin <= 1'h1;
    repeat (100) @(posedge mclk);
    sl = speed_lvl;
    @(posedge mclk);
    cmp("speed", led_chain, (sl == 4'h0) ? 8'h0 : 8'h1 << (sl - 4'h1));
    look(want(1, 1, 0, 0));
    wait_sig(0);
    look(want(1, 1, 1, 0));
    for (int i = 0; i < 12; i++) begin
      v = (i < 9) ? i : $urandom_range(8);
      power_lvl <= 4'(v);
      repeat (3) @(posedge mclk);
      cmp("bar", led_chain, (9'h1 << v) - 9'h1);
    end
    ce <= 1'h0;
    power_lvl <= (v == 0) ? 4'h8 : 4'h0;
    repeat (4) @(posedge mclk);
    cmp("freeze", led_chain, (9'h1 << v) - 9'h1);
    ce <= 1'h1;
    repeat (3) @(posedge mclk);
    cmp("thaw", led_chain, (v == 0) ? 33'hff : 33'h0);
    overload_pin <= 1'h1;
    look(want(1, 1, 1, 0) | 7'h2);
    overload_pin <= 1'h0;
    start_pin <= 1'h0;
    repeat (4) @(posedge mclk);
    cmp("stop", {motor_drive, at_speed_pin}, 33'h1);
    look(want(0, 1, 1, 0));
    wait_sig(1);
    look(7'h0);
    wait_sig(2);
    start_pin <= 1'h1;
    wait_sig(0);
    error_pin <= 1'h1;
    look(want(1, 1, 1, 1));
    error_pin <= 1'h0;
    wait_sig(2);
    look(want(1, 0, 0, 1));
    start_pin <= 1'h0;
    look(want(0, 0, 0, 0));
    for (int c = 1; c <= 8; c++) begin
      fault_code_pin <= 4'(c);
      error_pin <= 1'h1;
      start_pin <= c[0];
      look(want(c[0], 0, 0, 1));
      cmp("code", chain_or, 8'h1 << (c - 1));
      error_pin <= 1'h0;
      look(want(c[0], 0, 0, 1));
      apb(1'h0, 8'h04, 32'h0);
      cmp("state", q, 33'h1040 | (c << 8) | c[0]);
      if (c[0])
        start_pin <= 1'h0;
      else
        apb(1'h1, 8'h00, 32'h2);
      look(want(0, 0, 0, 0));
      apb(1'h1, 8'h00, 32'h0);
    end
    apb(1'h1, 8'h00, 32'h3);
    repeat (2) @(posedge mclk);
    cmp("remote start", motor_drive, 33'h1);
    apb(1'h1, 8'h00, 32'h2);
    repeat (2) @(posedge mclk);
    cmp("remote stop", motor_drive, 33'h0);
    apb(1'h0, 8'h08, 32'h0);
    cmp("events", q, 33'hf);
    cmp("irq", irq, 33'h1);
    apb(1'h1, 8'h0c, 32'h0);
    repeat (2) @(posedge mclk);
    cmp("irq", irq, 33'h0);
    apb(1'h1, 8'h08, 32'hf);
    apb(1'h0, 8'h08, 32'h0);
    cmp("cleared", q, 33'h0);
    cmp("irq", irq, 33'h0);
    give_verdict();
  end
endmodule : test_pump_drive_status_indicator
`default_nettype wire
